// [hdl/ane_pkg.sv]
/*
 * Constants for the auto-negotiation advertisement, partner ability and expansion registers:
 * register indices, byte addresses, field positions, reset values and strap timing.
 * Assumes a 32-bit APB register port with one 16-bit register in the low half of each word.
 */
package ane_pkg;

    localparam int REG_W = 16;
    localparam int APB_DW = 32;
    localparam int APB_AW = 8;

    // Register indices as numbered in the management map
    localparam logic [APB_AW-1:0] IDX_ADVERT = 8'h04;
    localparam logic [APB_AW-1:0] IDX_PARTNER = 8'h05;
    localparam logic [APB_AW-1:0] IDX_EXPAND = 8'h06;

    // Index to byte address: one aligned 32-bit word per register
    function automatic logic [APB_AW-1:0] ane_byte_addr(input logic [APB_AW-1:0] idx);
        return {idx[APB_AW-3:0], 2'h0};
    endfunction : ane_byte_addr

    localparam logic [APB_AW-1:0] ADDR_ADVERT = ane_byte_addr(IDX_ADVERT);
    localparam logic [APB_AW-1:0] ADDR_PARTNER = ane_byte_addr(IDX_PARTNER);
    localparam logic [APB_AW-1:0] ADDR_EXPAND = ane_byte_addr(IDX_EXPAND);

    // Local advertisement fields
    localparam int ADV_TEN_HALF = 5;
    localparam int ADV_SEL_W = 5;
    localparam logic [ADV_SEL_W-1:0] ADV_SEL_RESET = 5'h01;
    localparam logic ADV_TEN_HALF_RESET = 1'b0;

    // Partner base-page fields
    localparam int PB_NEXT_PAGE = 15;
    localparam int PB_ACK = 14;
    localparam int PB_REMOTE_FAULT = 13;
    localparam int PB_RESERVED = 12;
    localparam int PB_ASYM_PAUSE = 11;
    localparam int PB_SYM_PAUSE = 10;
    localparam int PB_T4 = 9;
    localparam int PB_TEN_HALF = 5;
    localparam logic [REG_W-1:0] PARTNER_RESET = 16'h0000;
    localparam logic [REG_W-1:0] PARTNER_MASK = 16'hEFFF;

    // Expansion fields
    localparam int EX_LOC_DEFINED = 6;
    localparam int EX_STORE_SEL = 5;
    localparam int EX_PAR_FAULT = 4;
    localparam int EX_PARTNER_NP = 3;
    localparam int EX_LOCAL_NP = 2;
    localparam int EX_PAGE_RX = 1;
    localparam int EX_PARTNER_AN = 0;
    localparam int EX_USED_W = 7;

    // Strap input synchroniser depth and settle cycles after reset release
    localparam int STRAP_STAGES = 3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum {STRAP_WAIT, STRAP_DONE} ane_strap_t;

endpackage : ane_pkg

// [hdl/ane_regs.sv]
/*
 * Auto-negotiation register bank: local advertisement low bits, partner base-page
 * abilities and the expansion status word, reached over an APB slave port.
 * Assumes the negotiation engine runs on sys_clk and delivers received pages as
 * one-cycle strobes with the page word; the 10BASE-Te half-duplex strap is a pin.
 */
// Chosen here: the APB interface to the registers.
// Notes on behaviour
// - Advertisement bit 5, 10BASE-Te half ability, writable, reset value from strap.
// - Advertisement selector bits 4:0 writable, reset 00001, sent in base page.
// - Partner register holds received base page; next pages do not overwrite it.
// - Partner bit 15 read-only, reset 0, shows partner wants next pages.
// - Partner bit 13 read-only, reset 0, shows partner remote fault.
// - Partner bit 12 reserved, reads 0; software writes 0.
// - Partner bits 11 and 10 show asymmetric and symmetric pause support.
// - Partner bits 9..5 show T4, TX full, TX, 10 full, 10 half abilities.
// - Partner bits 4:0 read-only, reset 0, partner protocol selector.
// - Expansion bits 15:7 reserved: writes ignored, reads 0.
// - Expansion bit 6 constant 1, storage location is defined.
// - Expansion bit 5 constant 1, next pages stored in register 8.
// - Expansion bit 4 read-only, reset 0, set on parallel detection fault.
// - Expansion bit 3 read-only, reset 0, partner supports next pages.
// - Expansion bit 2 constant 1, local device can send next pages.
// - Expansion bit 1 set on page received, cleared by software read.
// - Expansion bit 0 read-only, reset 0, partner supports auto-negotiation.
`timescale 1ns/1ps

module ane_regs (
    input wire logic sys_clk,                           // 20 MHz core clock
    input wire logic resetn,                            // Synchronous reset, active low
    input wire logic psel,                              // APB select
    input wire logic penable,                           // APB access phase
    input wire logic pwrite,                            // APB write when high
    input wire logic [ane_pkg::APB_AW-1:0] paddr,       // APB byte address
    input wire logic [ane_pkg::APB_DW-1:0] pwdata,      // APB write data
    input wire logic [3:0] pstrb,                       // APB byte strobes
    output logic [ane_pkg::APB_DW-1:0] prdata,          // APB read data
    output logic pready,                                // APB ready
    output logic pslverr,                               // APB error on unmapped address
    input wire logic tenHalfStrap,                      // Strap pin for 10BASE-Te half ability
    input wire logic pageRxStrobe,                      // One-cycle pulse: link code word received
    input wire logic pageIsBase,                        // Received page is the base page
    input wire logic [ane_pkg::REG_W-1:0] rxPageWord,   // Received link code word
    input wire logic parallelFaultEvt,                  // One-cycle pulse: parallel detection fault
    input wire logic negRestart,                        // One-cycle pulse: negotiation restarted
    input wire logic partnerNegDetect,                  // Level: partner negotiates
    output logic [ane_pkg::ADV_SEL_W:0] advertLow       // Advertised bits 5:0 for the base page
);
    import ane_pkg::*;

    logic [ADV_SEL_W-1:0] advertSel_q;
    logic advTenHalf_q;
    logic [REG_W-1:0] partnerWord_q;
    logic pdf_q;
    logic partnerNp_q;
    logic pageFlag_q;
    logic partnerAn_q;
    logic [APB_DW-1:0] prdata_q;
    logic [STRAP_STAGES-1:0] strapSync_q;
    logic [1:0] strapCnt_q;
    ane_strap_t strapState_q;

    // Bus decode
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire hitAdvert = (paddr == ADDR_ADVERT);
    wire hitPartner = (paddr == ADDR_PARTNER);
    wire hitExpand = (paddr == ADDR_EXPAND);
    wire addrHit = hitAdvert | hitPartner | hitExpand;
    wire advertWrite = accessPhase & pwrite & hitAdvert & pstrb[0];
    wire expandRead = accessPhase & ~pwrite & hitExpand;
    wire basePageIn = pageRxStrobe & pageIsBase;

    // Strap settle and agreement of the last two synchroniser stages
    wire strapAgree = (strapSync_q[STRAP_STAGES-2] == strapSync_q[STRAP_STAGES-1]);
    wire strapSettled = (strapCnt_q == STRAP_SETTLE);
    wire strapLoad = (strapState_q == STRAP_WAIT) & strapSettled & strapAgree & ~advertWrite;

    // Readable words
    wire [REG_W-1:0] advertWord = REG_W'({advTenHalf_q, advertSel_q});
    wire [REG_W-1:0] partnerWord = partnerWord_q & PARTNER_MASK;
    wire [EX_USED_W-1:0] expandLow = {1'b1, 1'b1, pdf_q, partnerNp_q, 1'b1,
                                      pageFlag_q, partnerAn_q};
    wire [REG_W-1:0] expandWord = REG_W'(expandLow);
    wire [REG_W-1:0] readWord = hitAdvert ? advertWord :
                                hitPartner ? partnerWord :
                                hitExpand ? expandWord : '0;

    // clear only what the read reported
    wire pageFlagClear = expandRead & prdata_q[EX_PAGE_RX];
    wire pageFlag_d = pageRxStrobe | (pageFlag_q & ~pageFlagClear);

    assign pready = accessPhase;
    assign pslverr = accessPhase & ~addrHit;
    assign prdata = prdata_q;
    assign advertLow = {advTenHalf_q, advertSel_q};

    // Read data captured in setup so the access phase needs no wait state
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prdata_q <= '0;
        end else if (setupPhase) begin
            prdata_q <= APB_DW'(readWord);
        end
    end

    // Strap pin synchroniser
    always_ff @(posedge sys_clk) begin
        strapSync_q <= {strapSync_q[STRAP_STAGES-2:0], tenHalfStrap};
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            strapCnt_q <= '0;
            strapState_q <= STRAP_WAIT;
        end else begin
            if (!strapSettled) begin
                strapCnt_q <= strapCnt_q + 2'h1;
            end
            if (strapLoad | advertWrite) begin
                strapState_q <= STRAP_DONE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            advertSel_q <= ADV_SEL_RESET;
            advTenHalf_q <= ADV_TEN_HALF_RESET;
        end else if (advertWrite) begin
            advertSel_q <= pwdata[ADV_SEL_W-1:0];
            advTenHalf_q <= pwdata[ADV_TEN_HALF];
        end else if (strapLoad) begin
            advTenHalf_q <= strapSync_q[STRAP_STAGES-1];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            partnerWord_q <= PARTNER_RESET;
        end else if (basePageIn) begin
            partnerWord_q <= rxPageWord & PARTNER_MASK;
        end
    end

    // partner status, fault held until restart
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pdf_q <= 1'b0;
            partnerNp_q <= 1'b0;
            partnerAn_q <= 1'b0;
        end else begin
            pdf_q <= parallelFaultEvt | (pdf_q & ~negRestart);
            if (basePageIn) begin
                partnerNp_q <= rxPageWord[PB_NEXT_PAGE];
            end else if (negRestart) begin
                partnerNp_q <= 1'b0;
            end
            partnerAn_q <= partnerNegDetect;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pageFlag_q <= 1'b0;
        end else begin
            pageFlag_q <= pageFlag_d;
        end
    end

    // Checks
    sequence s_expand_read;
        psel && !penable && !pwrite && hitExpand ##1 psel && penable;
    endsequence

    sequence s_base_page;
        pageRxStrobe && pageIsBase;
    endsequence

    a_selector_reset: assert property (
        @(posedge sys_clk) $past(!resetn) && resetn |-> advertSel_q == ADV_SEL_RESET)
        else $error("selector not at reset value");

    a_page_flag_set: assert property (
        @(posedge sys_clk) disable iff (!resetn) pageRxStrobe |=> pageFlag_q)
        else $error("page flag not set after page");

    a_read_clears_flag: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_expand_read ##0 (prdata[EX_PAGE_RX] && !pageRxStrobe) |=> !pageFlag_q)
        else $error("page flag not cleared by read");

    a_flag_not_lost: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_expand_read ##0 pageRxStrobe |=> pageFlag_q ##1 (pageFlag_q || expandRead))
        else $error("page event lost during read");

    a_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        psel && penable && hitPartner |-> !prdata[PB_RESERVED])
        else $error("reserved partner bit read as one");

    a_expand_fixed: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_expand_read |-> prdata[APB_DW-1:EX_USED_W] == '0
            && prdata[EX_LOC_DEFINED] && prdata[EX_STORE_SEL] && prdata[EX_LOCAL_NP])
        else $error("expansion fixed bits wrong");

    a_partner_capture: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q == ($past(rxPageWord) & PARTNER_MASK)
            && partnerNp_q == $past(rxPageWord[PB_NEXT_PAGE]))
        else $error("base page not captured");

    a_next_page_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        pageRxStrobe && !pageIsBase |=> $stable(partnerWord_q))
        else $error("next page overwrote base register");

    a_fault_sticky: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        parallelFaultEvt |=> pdf_q ##1 (pdf_q || $past(negRestart)))
        else $error("parallel fault not held");

    a_advert_write: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        advertWrite |=> advertLow == $past(pwdata[ADV_SEL_W:0]))
        else $error("advertisement write not stored");

    a_strap_load: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        strapLoad |=> advTenHalf_q == $past(strapSync_q[2]) && strapState_q == STRAP_DONE)
        else $error("strap not loaded");

    a_unmapped_error: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        psel && penable |-> pready && (pslverr == !addrHit))
        else $error("bus answer wrong");

    // Read path, capture and hold checks
    sequence s_partner_read;
        psel && !penable && !pwrite && hitPartner ##1 psel && penable;
    endsequence

    sequence s_advert_read;
        psel && !penable && !pwrite && hitAdvert ##1 psel && penable;
    endsequence

    sequence s_unmapped_read;
        psel && !penable && !pwrite && !addrHit ##1 psel && penable;
    endsequence

    a_partner_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_partner_read |-> prdata == APB_DW'($past(partnerWord_q) & PARTNER_MASK))
        else $error("partner read data wrong");

    a_partner_np: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[PB_NEXT_PAGE] == $past(rxPageWord[PB_NEXT_PAGE]))
        else $error("partner next page bit wrong");

    a_partner_ack: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[PB_ACK] == $past(rxPageWord[PB_ACK]))
        else $error("partner acknowledge bit wrong");

    a_partner_fault: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[PB_REMOTE_FAULT] == $past(rxPageWord[PB_REMOTE_FAULT]))
        else $error("partner remote fault bit wrong");

    a_partner_pause: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[PB_ASYM_PAUSE:PB_SYM_PAUSE]
            == $past(rxPageWord[PB_ASYM_PAUSE:PB_SYM_PAUSE]))
        else $error("partner pause bits wrong");

    a_partner_abilities: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[PB_T4:PB_TEN_HALF] == $past(rxPageWord[PB_T4:PB_TEN_HALF]))
        else $error("partner ability bits wrong");

    a_partner_selector: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_base_page |=> partnerWord_q[ADV_SEL_W-1:0] == $past(rxPageWord[ADV_SEL_W-1:0]))
        else $error("partner selector wrong");

    a_reserved_stored: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !partnerWord_q[PB_RESERVED])
        else $error("reserved partner bit stored as one");

    a_partner_idle: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !pageRxStrobe |=> $stable(partnerWord_q))
        else $error("partner register changed without page");

    a_advert_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_advert_read |-> prdata == APB_DW'($past(advertWord)))
        else $error("advertisement read data wrong");

    a_advert_ignored: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accessPhase && pwrite && hitAdvert && !pstrb[0] && !strapLoad |=> $stable(advertLow))
        else $error("advertisement changed without byte strobe");

    a_partner_ro: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accessPhase && pwrite && hitPartner && !pageRxStrobe |=> $stable(partnerWord_q))
        else $error("partner register written by bus");

    a_expand_ro: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accessPhase && pwrite && hitExpand && !pageRxStrobe && !parallelFaultEvt
            && !negRestart |=> $stable(pageFlag_q) && $stable(pdf_q))
        else $error("expansion register written by bus");

    a_fault_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        negRestart && !parallelFaultEvt |=> !pdf_q)
        else $error("parallel fault not cleared by restart");

    a_np_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        negRestart && !basePageIn |=> !partnerNp_q)
        else $error("partner next page ability not cleared");

    a_an_follow: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $past(resetn) |-> partnerAn_q == $past(partnerNegDetect))
        else $error("partner negotiation bit wrong");

    a_flag_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        pageFlag_q && !expandRead |=> pageFlag_q)
        else $error("page flag lost without read");

    a_flag_idle: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !pageFlag_q && !pageRxStrobe |=> !pageFlag_q)
        else $error("page flag set without page");

    a_expand_status: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_expand_read |-> prdata[EX_PAR_FAULT] == $past(pdf_q)
            && prdata[EX_PARTNER_NP] == $past(partnerNp_q)
            && prdata[EX_PARTNER_AN] == $past(partnerAn_q))
        else $error("expansion status bits wrong");

    a_read_stands: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accessPhase |=> $stable(prdata))
        else $error("read data moved after access");

    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_unmapped_read |-> prdata == '0)
        else $error("unmapped read data not zero");

    a_strap_done: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        strapState_q == STRAP_DONE |=> strapState_q == STRAP_DONE)
        else $error("strap capture repeated");

endmodule : ane_regs

// [verification/ane_link_partner.sv]
/*
 * Stand-in for the negotiation engine: received pages, fault and restart pulses, and
 * the partner's negotiation level. Assumes one clock shared with the register bank.
 */
`timescale 1ns/1ps

module ane_link_partner (
    input wire logic sys_clk,                       // Core clock
    output logic pageRxStrobe,                      // Page received pulse
    output logic pageIsBase,                        // Page is the base page
    output logic [ane_pkg::REG_W-1:0] rxPageWord,   // Received word
    output logic parallelFaultEvt,                  // Fault pulse
    output logic negRestart,                        // Restart pulse
    output logic partnerNegDetect                   // Partner negotiates
);
    import ane_pkg::*;

    initial begin
        pageRxStrobe = 1'b0;
        pageIsBase = 1'b0;
        rxPageWord = 16'h0000;
        parallelFaultEvt = 1'b0;
        negRestart = 1'b0;
        partnerNegDetect = 1'b0;
    end

    // Word is only valid with the strobe; afterwards show its inverse
    task automatic send_page(input logic [REG_W-1:0] w, input logic b);
        @(posedge sys_clk);
        pageRxStrobe <= 1'b1;
        pageIsBase <= b;
        rxPageWord <= w;
        @(posedge sys_clk);
        pageRxStrobe <= 1'b0;
        pageIsBase <= ~b;
        rxPageWord <= ~w;
    endtask : send_page

    task automatic pulse(input logic fault);
        @(posedge sys_clk);
        parallelFaultEvt <= fault;
        negRestart <= ~fault;
        @(posedge sys_clk);
        parallelFaultEvt <= 1'b0;
        negRestart <= 1'b0;
    endtask : pulse

    task automatic set_neg(input logic v);
        @(posedge sys_clk);
        partnerNegDetect <= v;
    endtask : set_neg

endmodule : ane_link_partner

// [verification/ane_regs_tb.sv]
/*
 * Bench for the negotiation register bank: APB master task, one task per scenario.
 * Assumes the link partner model stands in for the negotiation engine.
 */
`timescale 1ns/1ps

module ane_regs_tb;
    import ane_pkg::*;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [APB_DW-1:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic tenHalfStrap = 1'b1;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic pageRxStrobe, pageIsBase, parallelFaultEvt, negRestart, partnerNegDetect;
    logic [REG_W-1:0] rxPageWord;
    logic [ADV_SEL_W:0] advertLow;
    logic [APB_DW-1:0] rd;
    logic err;
    int errCount = 0;
    int checks = 0;
    int cycles = 0;

    always #25 sys_clk = ~sys_clk;

    ane_regs ane_regs_inst (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tenHalfStrap(tenHalfStrap),
        .pageRxStrobe(pageRxStrobe), .pageIsBase(pageIsBase), .rxPageWord(rxPageWord),
        .parallelFaultEvt(parallelFaultEvt), .negRestart(negRestart),
        .partnerNegDetect(partnerNegDetect), .advertLow(advertLow));

    ane_link_partner ane_link_partner_inst (.sys_clk(sys_clk), .pageRxStrobe(pageRxStrobe),
        .pageIsBase(pageIsBase), .rxPageWord(rxPageWord),
        .parallelFaultEvt(parallelFaultEvt), .negRestart(negRestart),
        .partnerNegDetect(partnerNegDetect));

    task automatic endSim();
        $display("errors %0d checks %0d", errCount, checks);
        if (errCount == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endSim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            errCount++;
        end
    endtask : chk

    // Setup cycle, then access until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk("pready", 1, n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(name, exp, rd);
    endtask : rdchk

    task automatic t_reset();
        rdchk("advert", ADDR_ADVERT, 32'h21);
        chk("advertLow", 32'h21, {26'h0, advertLow});
        chk("pslverr", 0, err);
        rdchk("partner", ADDR_PARTNER, 32'h0);
        rdchk("expand", ADDR_EXPAND, 32'h64);
    endtask : t_reset

    task automatic t_advert();
        apb(1'b1, ADDR_ADVERT, 32'hFFFF_FFDE, 4'hF);
        rdchk("advert", ADDR_ADVERT, 32'h1E);
        chk("advertLow", 32'h1E, {26'h0, advertLow});
        apb(1'b1, ADDR_ADVERT, 32'h3F, 4'hE);
        rdchk("advert", ADDR_ADVERT, 32'h1E);
        apb(1'b1, ADDR_ADVERT, 32'h21, 4'h1);
        ane_link_partner_inst.pulse(1'b0);
        rdchk("advert", ADDR_ADVERT, 32'h21);
        apb(1'b1, ADDR_PARTNER, 32'h0000_EFFF, 4'hF);
        apb(1'b1, ADDR_EXPAND, 32'hFFFF_FFFF, 4'hF);
        rdchk("partner", ADDR_PARTNER, 32'h0);
        rdchk("expand", ADDR_EXPAND, 32'h64);
    endtask : t_advert

    task automatic t_partner();
        ane_link_partner_inst.send_page(16'h2A15, 1'b1);
        rdchk("partner", ADDR_PARTNER, 32'h2A15);
        ane_link_partner_inst.send_page(16'h5541, 1'b1);
        rdchk("partner", ADDR_PARTNER, 32'h4541);
        ane_link_partner_inst.send_page(16'hFFFF, 1'b1);
        rdchk("partner", ADDR_PARTNER, 32'hEFFF);
        rdchk("expand", ADDR_EXPAND, 32'h6E);
        rdchk("expand", ADDR_EXPAND, 32'h6C);
        ane_link_partner_inst.send_page(16'h1234, 1'b0);
        rdchk("partner", ADDR_PARTNER, 32'hEFFF);
        rdchk("expand", ADDR_EXPAND, 32'h6E);
    endtask : t_partner

    task automatic t_fault();
        ane_link_partner_inst.pulse(1'b1);
        rdchk("expand", ADDR_EXPAND, 32'h7C);
        ane_link_partner_inst.pulse(1'b0);
        rdchk("expand", ADDR_EXPAND, 32'h64);
        ane_link_partner_inst.set_neg(1'b1);
        rdchk("expand", ADDR_EXPAND, 32'h65);
    endtask : t_fault

    // A page lands on the edge that completes the clearing read
    task automatic t_collide();
        ane_link_partner_inst.send_page(16'h0001, 1'b1);
        fork
            apb(1'b0, ADDR_EXPAND, 32'h0, 4'h0);
            begin
                @(posedge sys_clk);
                ane_link_partner_inst.send_page(16'h0001, 1'b1);
            end
        join
        chk("expand", 32'h67, rd);
        rdchk("expand", ADDR_EXPAND, 32'h67);
        rdchk("expand", ADDR_EXPAND, 32'h65);
        apb(1'b0, 8'h1C, 32'h0, 4'h0);
        chk("pslverr", 1, err);
        chk("unmapped", 32'h0, rd);
    endtask : t_collide

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            endSim();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        t_reset();
        t_advert();
        t_partner();
        t_fault();
        t_collide();
        endSim();
    end

endmodule : ane_regs_tb
